// file: src/podc_pkg.sv
/*
  package for the port output driver control block: register offsets,
  field positions, reset values, mode encodings and timing constants.
  assumes a 32-bit axi4-lite register bus and a 100 MHz cpu clock.
*/
package podc_pkg;
  // pin counts: per port and for all three ports
  localparam int unsigned PODC_NPIN        = 8;
  localparam int unsigned PODC_NALL        = 24;
  // register byte offsets
  localparam logic [7:0]  PODC_OFF_P2AUX   = 8'ha4;
  localparam logic [7:0]  PODC_OFF_P2SEC   = 8'ha8;
  localparam logic [7:0]  PODC_OFF_LATCH   = 8'h00;
  localparam logic [7:0]  PODC_OFF_MODE1   = 8'h04;
  localparam logic [7:0]  PODC_OFF_MODE2   = 8'h08;
  localparam logic [7:0]  PODC_OFF_PINS    = 8'h0c;
  localparam logic [7:0]  PODC_OFF_CFG     = 8'h10;
  // port2_mode_aux fields
  localparam int unsigned PODC_B_S2        = 7;
  localparam int unsigned PODC_B_S1        = 6;
  localparam int unsigned PODC_B_S0        = 5;
  localparam int unsigned PODC_B_CLKO      = 4;
  localparam int unsigned PODC_B_T1        = 3;
  localparam int unsigned PODC_B_T0        = 2;
  // fixed pin indices within the 24-bit pin vector
  localparam int unsigned PODC_PIN_P12     = 10;
  localparam int unsigned PODC_PIN_P13     = 11;
  localparam int unsigned PODC_PIN_P15     = 13;
  localparam int unsigned PODC_PIN_P20     = 16;
  localparam int unsigned PODC_PIN_P21     = 17;
  // timer toggle outputs sit on port 0 pins (choice)
  localparam int unsigned PODC_PIN_TOG1    = 7;
  localparam int unsigned PODC_PIN_TOG0    = 6;
  // reset values
  localparam logic [7:0]  PODC_RST_P2AUX   = 8'h00;
  localparam logic [23:0] PODC_RST_MODE    = 24'h000000;
  // strong pull-up pulse
  localparam int unsigned PODC_CLK_NS      = 10;
  localparam int unsigned PODC_STRONG_CLKS = 2;
  localparam int unsigned PODC_STRONG_CYC  = PODC_STRONG_CLKS;
  // mode encodings (first, second)
  typedef enum logic [1:0] {
    PODC_M_QUASI = 2'b00,
    PODC_M_PUSH  = 2'b01,
    PODC_M_INPUT = 2'b10,
    PODC_M_OPEN  = 2'b11
  } podc_mode_t;
  // axi write channel states, one-hot
  typedef enum logic [2:0] {
    PODC_W_IDLE = 3'b001,
    PODC_W_RESP = 3'b010,
    PODC_W_HOLD = 3'b100
  } podc_wst_t;
endpackage

// file: src/podc_pin.sv
/*
  one-pin driver decoder with strong pull-up pulse timer and
  two-stage input synchroniser. assumes latch and mode come from
  flip-flops of the parent and the pad is sampled synchronously.
*/
`timescale 1ns/1ns
module podc_pin
  import podc_pkg::*;
(
  input  wire logic       i_clk,     // cpu clock
  input  wire logic       i_rst,     // sync reset, high
  input  wire logic       i_latch,   // port latch
  input  wire logic [1:0] i_mode,    // first, second mode bits
  input  wire logic       i_pad,     // raw pad level
  input  wire logic       i_off,     // path disabled
  output logic            o_vweak,   // very weak pull-up
  output logic            o_weak,    // weak pull-up
  output logic            o_strong,  // strong pull-up
  output logic            o_pdn,     // pulldown
  output logic            o_sync     // synchronised level
);
  logic       s1_r, s1_nxt;        // first sync stage
  logic       s2_r, s2_nxt;        // second sync stage
  logic       lat_d_r;             // last latch value
  logic [1:0] cnt_r, cnt_nxt;      // strong pulse counter
  logic       vw_nxt, wk_nxt, st_nxt, pd_nxt;
  logic       vw_r, wk_r, st_r, pd_r;

  // next values for sync chain, pulse and drivers
  always_comb begin
    s1_nxt = i_pad;
    s2_nxt = s1_r;
    cnt_nxt = (cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0;
    if (i_latch && !lat_d_r && i_mode == PODC_M_QUASI)
      cnt_nxt = 2'(PODC_STRONG_CYC);
    vw_nxt = 1'b0;
    wk_nxt = 1'b0;
    st_nxt = 1'b0;
    pd_nxt = 1'b0;
    if (!i_off) begin
      case (i_mode)
        PODC_M_QUASI: begin
          vw_nxt = i_latch;
          wk_nxt = i_latch && s2_r;
          // pulse ends early if software drops the latch: no contention
          st_nxt = i_latch && (cnt_nxt != 2'h0);
          pd_nxt = !i_latch;
        end
        PODC_M_PUSH: begin
          st_nxt = i_latch;
          pd_nxt = !i_latch;
        end
        PODC_M_OPEN: begin
          pd_nxt = !i_latch;
        end
        default: begin
          // input only: all drivers off
          pd_nxt = 1'b0;
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      lat_d_r <= 1'b1;
      cnt_r   <= 2'h0;
      vw_r    <= 1'b0;
      wk_r    <= 1'b0;
      st_r    <= 1'b0;
      pd_r    <= 1'b0;
    end else begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      lat_d_r <= i_latch;
      cnt_r   <= cnt_nxt;
      vw_r    <= vw_nxt;
      wk_r    <= wk_nxt;
      st_r    <= st_nxt;
      pd_r    <= pd_nxt;
    end
  end

  assign o_vweak  = vw_r;
  assign o_weak   = wk_r;
  assign o_strong = st_r;
  assign o_pdn    = pd_r;
  assign o_sync   = s2_r;

  sequence podc_rise_s;
    i_latch && !lat_d_r && i_mode == PODC_M_QUASI && !i_off;
  endsequence
  sequence podc_stay_s;
    i_latch && i_mode == PODC_M_QUASI && !i_off;
  endsequence
  // on for the two clocks after the rise, off on the third
  property podc_pulse_p;
    @(posedge i_clk) disable iff (i_rst)
    podc_rise_s ##1 podc_stay_s [*2] |->
      ($past(o_strong) && o_strong) ##1 !o_strong;
  endproperty
  chk_strong_two_clk: assert property (podc_pulse_p)
    else $error("strong pull-up pulse not two clocks");

  chk_strong_ends: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_mode == PODC_M_QUASI && o_strong && $stable(i_latch)
      && $past(o_strong)) |=> !o_strong)
    else $error("strong pull-up held too long");

  chk_vweak_latch: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_mode == PODC_M_QUASI && !i_off && $stable(i_mode)) |=>
      o_vweak == $past(i_latch))
    else $error("very weak pull-up not following latch");

  chk_weak_pin: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_mode == PODC_M_QUASI && !i_off && !s2_r) |=> !o_weak)
    else $error("weak pull-up on while pin low");

  chk_open_nopull: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_mode == PODC_M_OPEN) |=> !o_vweak && !o_weak && !o_strong)
    else $error("pull-up on in open drain");

  chk_push_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_mode == PODC_M_PUSH && !i_off) |=>
      o_strong == $past(i_latch) && o_pdn == !$past(i_latch))
    else $error("push-pull drive wrong");
endmodule // podc_pin

// file: src/podc_top.sv
/*
  port output driver control: per-pin pull-up and pulldown enables for
  three 8-bit ports, fixed pins, reset level, schmitt selection, timer
  toggle outputs and clock output enable, with an axi4-lite register
  slave. assumes synchronous pads, a 100 MHz clock, sync active-high
  reset and a master that keeps to axi4-lite handshakes.
*/
// Behaviour
// - quasi mode: very weak pull-up follows latch
// - quasi weak pull-up needs latch and pin high
// - quasi latch rise gives strong pull-up two clocks
// - open drain: no pull-ups, pulldown when latch zero
// - push-pull: strong up on one, pulldown zero
// - port1 pins 2,3 fixed open drain
// - port1 pin 5 unconfigurable, input with internal reset
// - crystal option disables port2 pins 0 and 1
// - latches reset to level bit, quasi mode
// - per-port schmitt bits 7,6,5 select schmitt
// - port1 pins 2,3,5 always schmitt
// - bits 3,2 toggle pin on timer overflow unless a latch write commits in the same clock
// - bit 4 with rc/ext clock drives clock out
// - aux bits 1,0 with second register: port2 pin 0,1 modes
// - mode codes 00 quasi 01 push 10 input 11 open
// - quasi-bidirectional is the default mode
`timescale 1ns/1ns
module podc_top
  import podc_pkg::*;
(
  input  wire logic        I_MCLK,          // cpu clock
  input  wire logic        I_RST,           // sync reset, high
  input  wire logic        I_RESET_LEVEL,   // reset level of latches
  input  wire logic        I_INT_RESET,     // internal reset option
  input  wire logic        I_XTAL_OSC,      // crystal oscillator option
  input  wire logic        I_CLK_SRC_OK,    // rc or external clock used
  input  wire logic        I_OSC_CLK,       // clock to copy out
  input  wire logic        I_T0_OVF,        // timer 0 overflow pulse
  input  wire logic        I_T1_OVF,        // timer 1 overflow pulse
  input  wire logic [23:0] I_PAD,           // pad levels, p2:p1:p0
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [23:0]      O_VWEAK,         // very weak pull-ups
  output logic [23:0]      O_WEAK,          // weak pull-ups
  output logic [23:0]      O_STRONG,        // strong pull-ups
  output logic [23:0]      O_PDN,           // pulldowns
  output logic [23:0]      O_SCHMITT,       // schmitt input selected
  output logic [23:0]      O_IN_EN,         // input path enabled
  output logic             O_CLK_OUT,       // clock on osc second pin
  output logic             O_CLK_OUT_EN     // clock out enable
);
  logic [23:0] latch_r, latch_nxt;          // port latches
  logic [23:0] mode1_r, mode1_nxt;          // port_mode_first
  logic [23:0] mode2_r, mode2_nxt;          // port_mode_second
  logic [7:0]  aux_r, aux_nxt;              // port2_mode_aux
  logic [7:0]  sec_r, sec_nxt;              // port2_mode_second
  logic [23:0] eff1, eff2;                  // effective mode bits
  logic [23:0] off;                         // pin path disabled
  logic [23:0] syncd;                       // synchronised pins
  logic [23:0] smt_nxt, ien_nxt, ien_r;
  logic        cko_nxt, ckoe_nxt, ckoe_r;
  logic        rst_d_r;                     // reset seen last clock
  podc_wst_t   wst_r, wst_nxt;              // write channel state
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic        bv_r, bv_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        have_a_r, have_a_nxt, have_d_r, have_d_nxt;
  logic [7:0]  wa_r, wa_nxt;                // captured write address
  logic [32:0] wd_r, wd_nxt;                // strobe bit 0 and write data
  logic        arrdy_r, arrdy_nxt, rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // effective per-pin mode: fixed pins override, port2 low from aux and port2_mode_second
  always_comb begin
    eff1 = mode1_r;
    eff2 = mode2_r;
    eff1[PODC_PIN_P21:PODC_PIN_P20] = aux_r[1:0];
    eff2[PODC_PIN_P21:PODC_PIN_P20] = sec_r[1:0];
    eff1[PODC_PIN_P12] = 1'b1;
    eff2[PODC_PIN_P12] = 1'b1;
    eff1[PODC_PIN_P13] = 1'b1;
    eff2[PODC_PIN_P13] = 1'b1;
    // pin 5 is an input only
    eff1[PODC_PIN_P15] = 1'b1;
    eff2[PODC_PIN_P15] = 1'b0;
    off = '0;
    off[PODC_PIN_P20] = I_XTAL_OSC;
    // clock output owns osc second pin when enabled
    off[PODC_PIN_P21] = I_XTAL_OSC | ckoe_r;
  end
  genvar g;
  generate
    for (g = 0; g < PODC_NALL; g = g + 1) begin : g_pin
      podc_pin u_pin (
        .i_clk    (I_MCLK),
        .i_rst    (I_RST),
        .i_latch  (latch_r[g]),
        .i_mode   ({eff1[g], eff2[g]}),
        .i_pad    (I_PAD[g]),
        .i_off    (off[g]),
        .o_vweak  (O_VWEAK[g]),
        .o_weak   (O_WEAK[g]),
        .o_strong (O_STRONG[g]),
        .o_pdn    (O_PDN[g]),
        .o_sync   (syncd[g])
      );
    end
  endgenerate
  // input options and clock output, registered
  always_comb begin
    smt_nxt = {{8{aux_r[PODC_B_S2]}}, {8{aux_r[PODC_B_S1]}},
               {8{aux_r[PODC_B_S0]}}};
    smt_nxt[PODC_PIN_P12] = 1'b1;
    smt_nxt[PODC_PIN_P13] = 1'b1;
    smt_nxt[PODC_PIN_P15] = 1'b1;
    ien_nxt = ~off;
    // pin 5 input only with internal reset
    ien_nxt[PODC_PIN_P15] = I_INT_RESET;
    ckoe_nxt = aux_r[PODC_B_CLKO] & I_CLK_SRC_OK;
    cko_nxt  = ckoe_nxt & I_OSC_CLK;
  end
  // write channel: address and data in either order, then response
  always_comb begin
    wst_nxt    = wst_r;
    awrdy_nxt  = 1'b0;
    wrdy_nxt   = 1'b0;
    bv_nxt     = bv_r;
    bresp_nxt  = bresp_r;
    have_a_nxt = have_a_r;
    have_d_nxt = have_d_r;
    wa_nxt     = wa_r;
    wd_nxt     = wd_r;
    latch_nxt  = latch_r;
    mode1_nxt  = mode1_r;
    mode2_nxt  = mode2_r;
    aux_nxt    = aux_r;
    sec_nxt    = sec_r;
    if (aux_r[PODC_B_T1] && I_T1_OVF)
      latch_nxt[PODC_PIN_TOG1] = !latch_r[PODC_PIN_TOG1];
    if (aux_r[PODC_B_T0] && I_T0_OVF)
      latch_nxt[PODC_PIN_TOG0] = !latch_r[PODC_PIN_TOG0];
    case (wst_r)
      PODC_W_IDLE: begin
        if (S_AXI_AWVALID && awrdy_r) begin
          have_a_nxt = 1'b1;
          wa_nxt     = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wrdy_r) begin
          have_d_nxt = 1'b1;
          wd_nxt     = {S_AXI_WSTRB[0], S_AXI_WDATA}; // strobe need not stay
        end
        awrdy_nxt = !have_a_nxt;
        wrdy_nxt  = !have_d_nxt;
        if (have_a_nxt && have_d_nxt)
          wst_nxt = PODC_W_RESP;
      end
      PODC_W_RESP: begin
        // commit the write; only the low byte lane strobe gates it
        bresp_nxt = 2'b00;
        if (!wd_r[32] && wa_r != PODC_OFF_PINS) begin
          bresp_nxt = 2'b00;
        end else if (wa_r == PODC_OFF_P2AUX) begin
          aux_nxt = wd_r[7:0];
        end else if (wa_r == PODC_OFF_P2SEC) begin
          sec_nxt = wd_r[7:0];
        end else if (wa_r == PODC_OFF_LATCH) begin
          latch_nxt = wd_r[23:0];
        end else if (wa_r == PODC_OFF_MODE1) begin
          mode1_nxt = wd_r[23:0];
        end else if (wa_r == PODC_OFF_MODE2) begin
          mode2_nxt = wd_r[23:0];
        end else begin
          bresp_nxt = 2'b10;                // unmapped or read-only
        end
        bv_nxt  = 1'b1;
        wst_nxt = PODC_W_HOLD;
      end
      PODC_W_HOLD: begin
        if (S_AXI_BREADY) begin
          bv_nxt     = 1'b0;
          have_a_nxt = 1'b0;
          have_d_nxt = 1'b0;
          awrdy_nxt  = 1'b1;
          wrdy_nxt   = 1'b1;
          wst_nxt    = PODC_W_IDLE;
        end
      end
      default: wst_nxt = PODC_W_IDLE;
    endcase
  end
  // read channel: one read at a time, data from a register
  always_comb begin
    arrdy_nxt = arrdy_r;
    rv_nxt    = rv_r;
    rd_nxt    = rd_r;
    rresp_nxt = rresp_r;
    if (S_AXI_ARVALID && arrdy_r) begin
      arrdy_nxt = 1'b0;
      rv_nxt    = 1'b1;
      rresp_nxt = 2'b00;
      if (S_AXI_ARADDR == PODC_OFF_P2AUX)
        rd_nxt = {24'h0, aux_r};
      else if (S_AXI_ARADDR == PODC_OFF_P2SEC)
        rd_nxt = {24'h0, sec_r};
      else if (S_AXI_ARADDR == PODC_OFF_LATCH)
        rd_nxt = {8'h0, latch_r};
      else if (S_AXI_ARADDR == PODC_OFF_MODE1)
        rd_nxt = {8'h0, mode1_r};
      else if (S_AXI_ARADDR == PODC_OFF_MODE2)
        rd_nxt = {8'h0, mode2_r};
      else if (S_AXI_ARADDR == PODC_OFF_PINS)
        rd_nxt = {8'h0, syncd & ien_r};     // port read of pins
      else if (S_AXI_ARADDR == PODC_OFF_CFG)
        rd_nxt = {28'h0, ckoe_r, I_XTAL_OSC, I_INT_RESET, I_RESET_LEVEL};
      else begin
        rd_nxt    = 32'h0;
        rresp_nxt = 2'b10;
      end
    end else if (rv_r && S_AXI_RREADY) begin
      rv_nxt    = 1'b0;
      arrdy_nxt = 1'b1;
    end
  end
  // all state registers; reset loads constants only
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      mode1_r  <= PODC_RST_MODE;
      mode2_r  <= PODC_RST_MODE;
      aux_r    <= PODC_RST_P2AUX;
      sec_r    <= PODC_RST_P2AUX;
      latch_r  <= 24'h000000;
      rst_d_r  <= 1'b1;
      wst_r    <= PODC_W_IDLE;
      awrdy_r  <= 1'b0;
      wrdy_r   <= 1'b0;
      bv_r     <= 1'b0;
      bresp_r  <= 2'b00;
      have_a_r <= 1'b0;
      have_d_r <= 1'b0;
      wa_r     <= 8'h00;
      wd_r     <= 33'h0;
      arrdy_r  <= 1'b0;
      rv_r     <= 1'b0;
      rd_r     <= 32'h0;
      rresp_r  <= 2'b00;
      O_SCHMITT <= 24'h000000;
      ien_r    <= 24'h000000;
      O_CLK_OUT <= 1'b0;
      ckoe_r   <= 1'b0;
    end else begin
      rst_d_r  <= 1'b0;
      mode1_r  <= mode1_nxt;
      mode2_r  <= mode2_nxt;
      aux_r    <= aux_nxt;
      sec_r    <= sec_nxt;
      // latches take reset level on first clock after release
      latch_r  <= rst_d_r ? {24{I_RESET_LEVEL}} : latch_nxt;
      wst_r    <= wst_nxt;
      awrdy_r  <= rst_d_r ? 1'b1 : awrdy_nxt;
      wrdy_r   <= rst_d_r ? 1'b1 : wrdy_nxt;
      bv_r     <= bv_nxt;
      bresp_r  <= bresp_nxt;
      have_a_r <= have_a_nxt;
      have_d_r <= have_d_nxt;
      wa_r     <= wa_nxt;
      wd_r     <= wd_nxt;
      arrdy_r  <= rst_d_r ? 1'b1 : arrdy_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      rresp_r  <= rresp_nxt;
      O_SCHMITT <= smt_nxt;
      ien_r    <= ien_nxt;
      O_CLK_OUT <= cko_nxt;
      ckoe_r   <= ckoe_nxt;
    end
  end
  assign O_IN_EN = ien_r;
  assign O_CLK_OUT_EN = ckoe_r;
  assign S_AXI_AWREADY = awrdy_r;
  assign S_AXI_WREADY = wrdy_r;
  assign S_AXI_BVALID = bv_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arrdy_r;
  assign S_AXI_RVALID = rv_r;
  assign S_AXI_RDATA = rd_r;
  assign S_AXI_RRESP = rresp_r;
  chk_fixed_open: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    !O_VWEAK[PODC_PIN_P12] && !O_STRONG[PODC_PIN_P13])
    else $error("fixed open drain pin pulled up");
  chk_xtal_off: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    I_XTAL_OSC |=> !O_PDN[PODC_PIN_P20] && !O_PDN[PODC_PIN_P21]
      && !O_IN_EN[PODC_PIN_P20] && !O_IN_EN[PODC_PIN_P21])
    else $error("crystal pins still active");
  chk_schmitt_fixed: assert property (
    @(posedge I_MCLK) disable iff (I_RST || rst_d_r)
    O_SCHMITT[PODC_PIN_P15] && O_SCHMITT[PODC_PIN_P12])
    else $error("fixed pin lost schmitt input");
  chk_schmitt_port: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    $rose(aux_r[PODC_B_S1]) |=> O_SCHMITT[8] && O_SCHMITT[15])
    else $error("port one schmitt not selected");
  chk_reset_level: assert property (
    @(posedge I_MCLK) $fell(I_RST) |=> latch_r == {24{$past(I_RESET_LEVEL)}})
    else $error("latches not at reset level");
  chk_toggle_t1: assert property (
    @(posedge I_MCLK) disable iff (I_RST || rst_d_r)
    (aux_r[PODC_B_T1] && I_T1_OVF && wst_r != PODC_W_RESP) |=>
      latch_r[PODC_PIN_TOG1] != $past(latch_r[PODC_PIN_TOG1]))
    else $error("timer one toggle missed");
  chk_clock_out: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    !(aux_r[PODC_B_CLKO] && I_CLK_SRC_OK) |=> !O_CLK_OUT_EN)
    else $error("clock out enabled without source");
endmodule // podc_top

// file: verif/podc_pad_model.sv
/*
  pad model: external circuitry on the 24 port pins.
  assumes driver enables come from the block on the same clock.
*/
`timescale 1ns/1ns
module podc_pad_model (
  input  wire logic        i_clk,  // cpu clock
  input  wire logic [23:0] i_up,   // any pull-up on
  input  wire logic [23:0] i_pdn,  // pulldown on
  input  wire logic [23:0] i_ext,  // external sink on
  output logic      [23:0] o_pad   // pad level
);
  initial o_pad = '0;
  // a floating pin must not look stable, so it inverts every clock
  always @(posedge i_clk) begin
    o_pad <= ((o_pad ^ ~i_up) | i_up) & ~i_pdn & ~i_ext;
  end
endmodule // podc_pad_model

// file: verif/testbench.sv
/*
  testbench for podc_top: axi4-lite master tasks and directed scenarios.
  assumes a 100 MHz clock and the pad model on the far side.
*/
`timescale 1ns/1ns
module testbench;
  import podc_pkg::*;
  logic clk = 0, rst = 1, lvl = 1, intr = 0, xtal = 0, srcok = 0;
  logic oclk = 0, t0 = 0, t1 = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0]  awa = 0, ara = 0;   // bus addresses
  logic [31:0] wd = 0, rdat;       // write data, read result
  logic [1:0]  rres, wres;         // read and write responses
  logic [23:0] ext = 0;            // external sinks per pin
  wire logic awr, wrdy, bv, arr, rv, co, coe;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdw;
  wire logic [23:0] vw, wk, st, pd, sch, ien, pad;
  int miscompares = 0, comparisons = 0, cyc = 0, sc = 0;
  podc_top uut (.I_MCLK(clk), .I_RST(rst), .I_RESET_LEVEL(lvl),
    .I_INT_RESET(intr), .I_XTAL_OSC(xtal), .I_CLK_SRC_OK(srcok),
    .I_OSC_CLK(oclk), .I_T0_OVF(t0), .I_T1_OVF(t1), .I_PAD(pad),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdw), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .O_VWEAK(vw), .O_WEAK(wk),
    .O_STRONG(st), .O_PDN(pd), .O_SCHMITT(sch), .O_IN_EN(ien),
    .O_CLK_OUT(co), .O_CLK_OUT_EN(coe));
  podc_pad_model pads (.i_clk(clk), .i_up(vw | wk | st), .i_pdn(pd),
    .i_ext(ext), .o_pad(pad));
  always #5 clk = ~clk;
  // cycle count, strong pulse width on pin 0, timeout
  always @(posedge clk) begin
    cyc++;
    oclk <= ~oclk;
    if (st[0] === 1'b1) sc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask
  // write: both channels offered together, dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 0;
      if (wrdy === 1'b1) wv <= 0;
    end while (bv !== 1'b1);
    wres = bresp;
    br <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1);
    rdat = rdw; rres = rresp; rr <= 0;
  endtask
  task automatic t_reset(input logic l);
    lvl <= l; rst <= 1;
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(PODC_OFF_LATCH); chk(rdat, {8'h00, {24{l}}});
    rd(PODC_OFF_P2AUX); chk(rdat, PODC_RST_P2AUX);
    rd(PODC_OFF_MODE1); chk(rdat, PODC_RST_MODE);
    chk(vw, {24{l}} & ~24'h002c00);
  endtask
  task automatic t_quasi;
    wr(PODC_OFF_LATCH, 24'hfffffe);
    repeat (3) @(posedge clk);
    sc = 0;
    wr(PODC_OFF_LATCH, 24'hffffff);
    repeat (8) @(posedge clk);
    chk(sc, PODC_STRONG_CLKS);
    ext[0] <= 1;
    repeat (8) @(posedge clk);
    chk({vw[0], wk[0]}, 2'b10);
    ext[0] <= 0;
    repeat (8) @(posedge clk);
    chk(wk[0], 1);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(PODC_OFF_MODE1, m[1] << 1);
      wr(PODC_OFF_MODE2, m[0] << 1);
      wr(PODC_OFF_LATCH, 24'hffffff);
      repeat (4) @(posedge clk);
      chk(st[1], m == 1);
      chk(vw[1] | wk[1] | st[1], m < 2);
      wr(PODC_OFF_LATCH, 24'hfffffd);
      repeat (4) @(posedge clk);
      chk({pd[1], vw[1] | wk[1] | st[1]}, {m != 2, 1'b0});
    end
    wr(PODC_OFF_MODE1, 0);
    wr(PODC_OFF_MODE2, 24'h000400);
    wr(PODC_OFF_LATCH, 24'hffffff);
    repeat (4) @(posedge clk);
    chk(vw[10] | wk[10] | st[10], 0);
    wr(PODC_OFF_LATCH, 24'hfffbff);
    repeat (4) @(posedge clk);
    chk(pd[10], 1);
    wr(PODC_OFF_MODE2, 0);
  endtask
  task automatic t_schmitt;
    logic [7:0]  sa [4] = '{8'h00, 8'h20, 8'h40, 8'h80};
    logic [23:0] se [4] = '{24'h002c00, 24'h002cff, 24'h00ff00, 24'hff2c00};
    for (int i = 0; i < 4; i++) begin
      wr(PODC_OFF_P2AUX, sa[i]);
      repeat (3) @(posedge clk);
      chk(sch, se[i]);
    end
  endtask
  task automatic t_timer;
    wr(PODC_OFF_LATCH, 24'hffffff);
    wr(PODC_OFF_P2AUX, 8'h0c);
    chk(wres, 2'b00);
    t0 <= 1;
    @(posedge clk);
    t0 <= 0;
    rd(PODC_OFF_LATCH); chk(rdat, 24'hffffbf);
    t1 <= 1;
    @(posedge clk);
    t1 <= 0;
    rd(PODC_OFF_LATCH); chk(rdat, 24'hffff3f);
    rd(PODC_OFF_P2AUX); chk(rdat, 8'h0c);
    wr(PODC_OFF_LATCH, 24'hffffff);
  endtask
  task automatic t_config;
    xtal <= 1; intr <= 1; srcok <= 1;
    wr(PODC_OFF_P2AUX, 8'h10);
    repeat (4) @(posedge clk);
    chk({ien[17:16], vw[17:16]}, 0);
    chk({ien[13], coe, co ^ oclk}, 3'b111);
    xtal <= 0; intr <= 0; srcok <= 0;
    wr(PODC_OFF_P2AUX, 8'h01);
    wr(PODC_OFF_P2SEC, 8'h01);
    repeat (4) @(posedge clk);
    chk({ien[13], coe, co, ien[16]}, 4'b0001);
    chk(vw[16] | wk[16] | st[16], 0);
    wr(PODC_OFF_P2AUX, 8'h00);
    repeat (4) @(posedge clk);
    chk(st[16], 1);
    rd(8'h40); chk({rres, rdat}, {2'b10, 32'h0});
    wr(PODC_OFF_PINS, 0);
    chk(wres, 2'b10);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    t_reset(1);
    t_quasi;
    t_modes;
    t_schmitt;
    t_timer;
    t_config;
    t_reset(0);
    tally_and_finish;
  end
endmodule // testbench
